// >>> rtl/lmi_pkg.sv
// constants, types and register map of the link mode indicator control
// assumes a single 20 MHz core clock and a plain strobe register port
package lmi_pkg;

    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned RESTORE_HOLD_MS = 3000;
    localparam int unsigned FAST_HALF_MS = 100;
    localparam int unsigned SLOW_HALF_MS = 500;
    localparam int unsigned RESTORE_HOLD_CYC = RESTORE_HOLD_MS * CYC_PER_MS;
    localparam int unsigned FAST_HALF_CYC = FAST_HALF_MS * CYC_PER_MS;
    localparam int unsigned SLOW_HALF_CYC = SLOW_HALF_MS * CYC_PER_MS;
    localparam logic [1:0] RESTORE_FLASHES = 2'h3;
    localparam logic [1:0] BOOT_SETTLE_CYC = 2'h3;

    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_UART = 8'h04;
    localparam logic [7:0] REG_MODE = 8'h08;
    localparam logic [7:0] REG_PIN = 8'h0c;
    localparam logic [7:0] REG_PEER_LO = 8'h10;
    localparam logic [7:0] REG_PEER_HI = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;
    localparam logic [3:0] REG_NAME_PAGE = 4'h2;

    // field positions
    localparam int unsigned CTRL_REBOOT_BIT = 0;
    localparam int unsigned UART_BAUD_LSB = 0;
    localparam int unsigned UART_PARITY_LSB = 4;
    localparam int unsigned UART_STOP2_BIT = 6;
    localparam int unsigned UART_FLOW_BIT = 7;
    localparam int unsigned MODE_MASTER_BIT = 0;
    localparam int unsigned MODE_DISC_BIT = 1;
    localparam int unsigned MODE_AUTOREC_BIT = 2;
    localparam int unsigned MODE_RCNT_LSB = 8;
    localparam int unsigned STAT_PHASE_BIT = 4;
    localparam int unsigned STAT_SETUP_BIT = 5;

    // baud codes 0..10 = 1200,2400,4800,9600,19200,38400,57600,115200,
    // 230400,460800,921600
    localparam logic [3:0] BAUD_115200 = 4'h7;
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ODD = 2'h1;
    localparam logic [1:0] PAR_EVEN = 2'h2;

    typedef enum logic [2:0] {
        ST_BOOT,
        ST_SCAN,
        ST_WAIT,
        ST_LINKED,
        ST_IDLE,
        ST_CONFIG,
        ST_RESTORE
    } lmi_state_t;

    typedef struct packed {
        logic [3:0] baud;
        logic [1:0] parity;
        logic stop2;
        logic flow;
        logic master;
        logic disc;
        logic autorec;
        logic [7:0] rcnt;
        logic [15:0] pin;
        logic [47:0] peer;
        logic [127:0] name;
    } lmi_cfg_t;

    // "Serial Adapter", first character in the low byte
    localparam logic [127:0] NAME_DFLT =
        128'h0000_7265_7470_6164_4120_6c61_6972_6553;
    localparam logic [15:0] PIN_DFLT = 16'h0000;

    localparam lmi_cfg_t CFG_DFLT = '{
        baud: BAUD_115200,
        parity: PAR_NONE,
        stop2: 1'b0,
        flow: 1'b0,
        master: 1'b0,
        disc: 1'b1,
        autorec: 1'b1,
        rcnt: 8'h00,
        pin: PIN_DFLT,
        peer: 48'h0000_0000_0000,
        name: NAME_DFLT
    };

endpackage

// >>> rtl/lmi_ctrl.sv
// mode, indicator and button controller with its configuration store
// assumes buttons and reset from pins, link_up from same-clock radio logic
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ns
module lmi_ctrl
    import lmi_pkg::*;
#(
    parameter int unsigned HOLD_CYC = RESTORE_HOLD_CYC,
    parameter int unsigned FAST_CYC = FAST_HALF_CYC,
    parameter int unsigned SLOW_CYC = SLOW_HALF_CYC
)
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic setup_btn_n,
    input wire logic restore_btn_n,
    input wire logic link_up,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic led_blue,
    output logic led_red,
    output logic config_mode,
    output logic connect_req,
    output logic advertise,
    output logic reconnect_last,
    output logic restore_busy,
    output logic [3:0] uart_baud_sel,
    output logic [1:0] uart_parity,
    output logic uart_stop2,
    output logic uart_flow_en,
    output logic [15:0] pin_code,
    output logic [47:0] peer_addr,
    output logic [127:0] device_name
);

    if (HOLD_CYC < 2 || FAST_CYC < 1 || SLOW_CYC < 1)
    begin : g_bad_param
        $error("lmi_ctrl: counts too small");
    end

    typedef struct packed {
        lmi_state_t state;
        logic [31:0] cnt;
        logic phase;
        logic [1:0] flashes;
        logic [31:0] hold;
        logic [1:0] boot;
        logic [7:0] attempts;
        logic setup_s1;
        logic setup_s2;
        logic setup_seen;
        logic rest_s1;
        logic rest_s2;
        lmi_cfg_t stored;
        lmi_cfg_t active;
        logic [31:0] rdata;
        logic led_b;
        logic led_r;
        logic cfg_mode;
        logic conn_req;
        logic adv;
        logic rec_last;
        logic rst_busy;
    } lmi_regs_t;

    lmi_regs_t s;
    lmi_regs_t next_s;
    logic [1:0] rst_sync;

    function automatic logic is_name(input logic [7:0] a);
        return a[7:4] == REG_NAME_PAGE;
    endfunction

    // state to enter once the mode is settled
    function automatic lmi_state_t role_state(input lmi_cfg_t c);
        if (c.master)
        begin
            // master needs a stored peer before it may initiate
            return (c.peer != 48'h0) ? ST_SCAN : ST_IDLE;
        end
        return ST_WAIT;
    endfunction

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end

    always_comb
    begin
        logic [31:0] half;
        logic wrap;
        logic hit;
        logic do_boot;
        half = 32'(FAST_CYC);
        wrap = 1'b0;
        hit = 1'b0;
        do_boot = 1'b0;
        next_s = s;
        next_s.rdata = 32'h0;
        next_s.setup_s1 = setup_btn_n;
        next_s.setup_s2 = s.setup_s1;
        next_s.rest_s1 = restore_btn_n;
        next_s.rest_s2 = s.rest_s1;

        // blink timer
        if (s.state == ST_WAIT || s.state == ST_CONFIG)
            half = 32'(SLOW_CYC);
        wrap = (s.cnt >= half - 32'h1);
        if (wrap)
        begin
            next_s.cnt = 32'h0;
            next_s.phase = ~s.phase;
        end
        else
            next_s.cnt = s.cnt + 32'h1;

        // restore button hold timer, fires once per press
        if (!s.rest_s2)
        begin
            if (s.hold != 32'(HOLD_CYC))
                next_s.hold = s.hold + 32'h1;
            hit = (s.hold == 32'(HOLD_CYC - 1));
        end
        else
            next_s.hold = 32'h0;

        unique case (s.state)
            ST_BOOT:
            begin
                next_s.boot = s.boot + 2'h1;
                if (s.boot == BOOT_SETTLE_CYC - 2'h1)
                begin
                    next_s.setup_seen = ~s.setup_s2;
                    if (!s.setup_s2)
                        next_s.state = ST_CONFIG;
                    else
                        next_s.state = role_state(s.active);
                end
            end
            ST_SCAN, ST_WAIT:
            begin
                if (link_up)
                    next_s.state = ST_LINKED;
            end
            ST_LINKED:
            begin
                if (!link_up)
                begin
                    if (!s.active.autorec)
                        next_s.state = ST_IDLE;
                    else if (s.active.rcnt != 8'h0 &&
                             s.attempts == s.active.rcnt)
                        next_s.state = ST_IDLE;
                    else
                    begin
                        // zero count never runs out
                        next_s.attempts = s.attempts + 8'h1;
                        next_s.state = role_state(s.active);
                    end
                end
            end
            ST_IDLE, ST_CONFIG:
            begin
            end
            ST_RESTORE:
            begin
                if (wrap && s.phase)
                begin
                    next_s.flashes = s.flashes + 2'h1;
                    if (s.flashes == RESTORE_FLASHES - 2'h1)
                    begin
                        next_s.stored = CFG_DFLT;
                        next_s.state = role_state(s.active);
                    end
                end
            end
        endcase

        // register writes
        if (reg_wr)
        begin
            if (reg_addr == REG_CTRL)
                do_boot = reg_wdata[CTRL_REBOOT_BIT];
            else if (s.state == ST_CONFIG)
            begin
                if (is_name(reg_addr))
                    next_s.stored.name[{reg_addr[3:2], 5'h00} +: 32] =
                        reg_wdata;
                else
                begin
                    unique case (reg_addr)
                        REG_UART:
                        begin
                            next_s.stored.baud =
                                reg_wdata[UART_BAUD_LSB +: 4];
                            next_s.stored.parity =
                                reg_wdata[UART_PARITY_LSB +: 2];
                            next_s.stored.stop2 = reg_wdata[UART_STOP2_BIT];
                            next_s.stored.flow = reg_wdata[UART_FLOW_BIT];
                        end
                        REG_MODE:
                        begin
                            next_s.stored.master =
                                reg_wdata[MODE_MASTER_BIT];
                            next_s.stored.disc =
                                reg_wdata[MODE_DISC_BIT];
                            next_s.stored.autorec =
                                reg_wdata[MODE_AUTOREC_BIT];
                            next_s.stored.rcnt =
                                reg_wdata[MODE_RCNT_LSB +: 8];
                        end
                        REG_PIN:
                            next_s.stored.pin = reg_wdata[15:0];
                        REG_PEER_LO:
                            next_s.stored.peer[31:0] = reg_wdata;
                        REG_PEER_HI:
                            next_s.stored.peer[47:32] = reg_wdata[15:0];
                        default:
                        begin
                        end
                    endcase
                end
            end
        end

        // register reads, data in the following cycle
        if (reg_rd)
        begin
            if (is_name(reg_addr))
                next_s.rdata = s.stored.name[{reg_addr[3:2], 5'h00} +: 32];
            else
            begin
                unique case (reg_addr)
                    REG_UART:
                        next_s.rdata = {24'h0, s.stored.flow, s.stored.stop2,
                                        s.stored.parity, s.stored.baud};
                    REG_MODE:
                        next_s.rdata = {16'h0, s.stored.rcnt, 5'h0,
                                        s.stored.autorec, s.stored.disc,
                                        s.stored.master};
                    REG_PIN:
                        next_s.rdata = {16'h0, s.stored.pin};
                    REG_PEER_LO:
                        next_s.rdata = s.stored.peer[31:0];
                    REG_PEER_HI:
                        next_s.rdata = {16'h0, s.stored.peer[47:32]};
                    REG_STATUS:
                        next_s.rdata = {26'h0, s.setup_seen, s.phase,
                                        1'b0, s.state};
                    default:
                        next_s.rdata = 32'h0;
                endcase
            end
        end

        // software reboot stands in for a power cycle
        if (do_boot)
        begin
            next_s.state = ST_BOOT;
            next_s.boot = 2'h0;
            next_s.attempts = 8'h0;
            next_s.active = s.stored;
        end
        else if (hit && s.state != ST_BOOT && s.state != ST_RESTORE)
        begin
            next_s.state = ST_RESTORE;
            next_s.flashes = 2'h0;
        end

        // each new mode starts its blink from the beginning
        if (next_s.state != s.state)
        begin
            next_s.cnt = 32'h0;
            next_s.phase = (next_s.state == ST_RESTORE);
        end

        // indicators
        next_s.led_b = 1'b0;
        next_s.led_r = 1'b0;
        unique case (next_s.state)
            ST_SCAN, ST_WAIT:
            begin
                next_s.led_b = next_s.phase;
            end
            ST_LINKED:
            begin
                next_s.led_b = 1'b1;
            end
            ST_CONFIG:
            begin
                next_s.led_b = ~next_s.phase;
                next_s.led_r = next_s.phase;
            end
            ST_RESTORE:
            begin
                next_s.led_b = next_s.phase;
                next_s.led_r = next_s.phase;
            end
            ST_BOOT, ST_IDLE:
            begin
            end
        endcase

        next_s.cfg_mode = (next_s.state == ST_CONFIG);
        next_s.conn_req = (next_s.state == ST_SCAN);
        next_s.adv = (next_s.state == ST_WAIT) &&
                     next_s.active.disc;
        next_s.rec_last = ~next_s.active.master &&
                          next_s.active.autorec;
        next_s.rst_busy = (next_s.state == ST_RESTORE);
    end

    always_ff @(posedge core_clk or negedge rst_sync[1])
    begin
        if (!rst_sync[1])
        begin
            s <= '0;
            s.setup_s1 <= 1'b1;
            s.setup_s2 <= 1'b1;
            s.rest_s1 <= 1'b1;
            s.rest_s2 <= 1'b1;
            s.stored <= CFG_DFLT;
            s.active <= CFG_DFLT;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign reg_rdata = s.rdata;
    assign led_blue = s.led_b;
    assign led_red = s.led_r;
    assign config_mode = s.cfg_mode;
    assign connect_req = s.conn_req;
    assign advertise = s.adv;
    assign reconnect_last = s.rec_last;
    assign restore_busy = s.rst_busy;
    assign uart_baud_sel = s.active.baud;
    assign uart_parity = s.active.parity;
    assign uart_stop2 = s.active.stop2;
    assign uart_flow_en = s.active.flow;
    assign pin_code = s.active.pin;
    assign peer_addr = s.active.peer;
    assign device_name = s.active.name;

endmodule

// >>> tb/lmi_ctrl_chk.sv
// port checker for the link mode indicator controller
// assumes it is bound into lmi_ctrl and sees only its ports
`timescale 1ns/1ns
module lmi_ctrl_chk
    import lmi_pkg::*;
#(
    parameter int unsigned HOLD_CYC = RESTORE_HOLD_CYC,
    parameter int unsigned FAST_CYC = FAST_HALF_CYC,
    parameter int unsigned SLOW_CYC = SLOW_HALF_CYC
)
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic restore_btn_n,
    input wire logic link_up,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic led_blue,
    input wire logic led_red,
    input wire logic config_mode,
    input wire logic connect_req,
    input wire logic advertise,
    input wire logic restore_busy,
    input wire logic [3:0] uart_baud_sel,
    input wire logic [15:0] pin_code,
    input wire logic [47:0] peer_addr
);
    int unsigned low_cnt;
    int unsigned busy_cnt;
    int unsigned blue_run;
    logic blue_q;
    logic scan_rise;
    logic wait_rise;
    logic reboot;
    assign reboot = reg_wr && reg_addr == REG_CTRL && reg_wdata[0];
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // press length, busy length and length of each blue indicator level
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            low_cnt <= 0;
            busy_cnt <= 0;
            blue_run <= 0;
            blue_q <= 1'b0;
            scan_rise <= 1'b0;
            wait_rise <= 1'b0;
        end
        else
        begin
            low_cnt <= restore_btn_n ? 0 : low_cnt + 1;
            busy_cnt <= restore_busy ? busy_cnt + 1 : 0;
            blue_run <= (led_blue != blue_q) ? 1 : blue_run + 1;
            blue_q <= led_blue;
            scan_rise <= (led_blue != blue_q || scan_rise) && connect_req
                && !link_up && !restore_busy;
            wait_rise <= (led_blue != blue_q || wait_rise) && advertise
                && !link_up && !restore_busy;
        end
    end
    AST_SCAN_RATE: assert property ($fell(led_blue) && connect_req
        && scan_rise |-> blue_run == FAST_CYC)
        else $error("scan blink half period wrong");
    AST_WAIT_RATE: assert property ($fell(led_blue) && advertise
        && wait_rise |-> blue_run == SLOW_CYC)
        else $error("wait blink half period wrong");
    AST_LINKED_ON: assert property (link_up [*8] ##0 !restore_busy
        |-> led_blue)
        else $error("blue not steady while linked");
    AST_CFG_ALT: assert property (config_mode && !restore_busy
        |-> led_red != led_blue)
        else $error("config indicators not alternating");
    AST_CFG_RATE: assert property (config_mode && $past(config_mode)
        && $changed(led_blue) |-> blue_run == SLOW_CYC)
        else $error("config swap period wrong");
    AST_RESTORE_QUAL: assert property ($rose(restore_busy)
        |-> low_cnt >= HOLD_CYC)
        else $error("restore began before full hold");
    AST_RESTORE_BOTH: assert property (restore_busy
        |-> led_red == led_blue)
        else $error("restore flash not simultaneous");
    AST_RESTORE_LEN: assert property ($fell(restore_busy)
        |-> busy_cnt == 5 * FAST_CYC)
        else $error("restore flash sequence length wrong");
    AST_SLAVE_PASSIVE: assert property (advertise |-> !connect_req)
        else $error("slave initiating a connection");
    AST_ACTIVE_HOLD: assert property ($changed({uart_baud_sel,
        pin_code, peer_addr}) |-> $past(reboot) || $past(reboot, 2))
        else $error("active settings changed without reboot");
    AST_RDATA_IDLE: assert property (!$past(reg_rd)
        |-> reg_rdata == 32'h0)
        else $error("read data outside read answer");
endmodule
bind lmi_ctrl lmi_ctrl_chk #(.HOLD_CYC(HOLD_CYC), .FAST_CYC(FAST_CYC),
    .SLOW_CYC(SLOW_CYC)) u_chk (.core_clk(core_clk), .rst_n(rst_n),
    .restore_btn_n(restore_btn_n), .link_up(link_up), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .led_blue(led_blue), .led_red(led_red),
    .config_mode(config_mode), .connect_req(connect_req),
    .advertise(advertise), .restore_busy(restore_busy),
    .uart_baud_sel(uart_baud_sel), .pin_code(pin_code),
    .peer_addr(peer_addr));

// >>> tb/lmi_user_model.sv
// user buttons and a remote peer that connects when asked or advertised
// assumes its commands change just after a rising edge of core_clk
`timescale 1ns/1ns
module lmi_user_model
#(
    parameter int unsigned LINK_LAT = 5
)
(
    input wire logic core_clk,
    input wire logic hold_setup,
    input wire logic hold_restore,
    input wire logic peer_on,
    input wire logic connect_req,
    input wire logic advertise,
    output logic setup_btn_n = 1'b1,
    output logic restore_btn_n = 1'b1,
    output logic link_up = 1'b0
);
    int unsigned lat = 0;
    always @(posedge core_clk)
    begin
        setup_btn_n <= !hold_setup;
        restore_btn_n <= !hold_restore;
        if (!peer_on)
        begin
            link_up <= 1'b0;
            lat <= 0;
        end
        else if (connect_req || advertise)
        begin
            lat <= lat + 1;
            if (lat == LINK_LAT)
                link_up <= 1'b1;
        end
    end
endmodule

// >>> tb/tb.sv
// self-checking bench for the link mode indicator controller
// assumes short counts on lmi_ctrl and the user model at its pins
`timescale 1ns/1ns
module tb
    import lmi_pkg::*;
;
    localparam int unsigned HOLD = 20;
    localparam int unsigned FAST = 4;
    localparam int unsigned SLOW = 8;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic hold_setup = 1'b1;
    logic hold_restore = 1'b0;
    logic peer_on = 1'b0;
    logic setup_btn_n, restore_btn_n, link_up, led_blue, led_red;
    logic config_mode, connect_req, advertise, reconnect_last;
    logic restore_busy, uart_stop2, uart_flow_en;
    logic [31:0] reg_rdata;
    logic [31:0] q;
    logic [3:0] uart_baud_sel;
    logic [1:0] uart_parity;
    logic [15:0] pin_code;
    logic [47:0] peer_addr;
    logic [127:0] device_name;
    int n_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    lmi_ctrl #(.HOLD_CYC(HOLD), .FAST_CYC(FAST), .SLOW_CYC(SLOW)) uut (
        .core_clk(core_clk), .rst_n(rst_n), .setup_btn_n(setup_btn_n),
        .restore_btn_n(restore_btn_n), .link_up(link_up),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .led_blue(led_blue),
        .led_red(led_red), .config_mode(config_mode),
        .connect_req(connect_req), .advertise(advertise),
        .reconnect_last(reconnect_last), .restore_busy(restore_busy),
        .uart_baud_sel(uart_baud_sel), .uart_parity(uart_parity),
        .uart_stop2(uart_stop2), .uart_flow_en(uart_flow_en),
        .pin_code(pin_code), .peer_addr(peer_addr),
        .device_name(device_name));
    lmi_user_model user (.core_clk(core_clk), .hold_setup(hold_setup),
        .hold_restore(hold_restore), .peer_on(peer_on),
        .connect_req(connect_req), .advertise(advertise),
        .setup_btn_n(setup_btn_n), .restore_btn_n(restore_btn_n),
        .link_up(link_up));
    initial
    begin
        forever #25 core_clk = ~core_clk;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            $display("mismatch timeout expected done seen hang");
            n_errors++;
            summarize();
        end
    end
    task automatic check(input string what, input logic [127:0] seen,
        input logic [127:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // one strobe cycle, read answer lands in q
    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= wr;
        reg_rd <= !wr;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(negedge core_clk);
        q = reg_rdata;
    endtask
    // cycles of one full blue level after the next change
    task automatic half(output int n);
        logic v;
        int k;
        n = 0;
        @(negedge core_clk);
        v = led_blue;
        for (k = 0; k < 40 && led_blue === v; k++)
            @(negedge core_clk);
        v = led_blue;
        while (n < 40 && led_blue === v)
        begin
            n++;
            @(negedge core_clk);
        end
    endtask
    task automatic t_config();
        int same = 0;
        int n;
        check("config_mode", config_mode, 1'b1);
        @(posedge core_clk);
        hold_setup <= 1'b0;
        repeat (3 * SLOW) @(negedge core_clk) same += int'(led_red === led_blue);
        check("alternation", same, 0);
        bus(1'b0, REG_STATUS, 32'h0);
        check("config state", q[2:0], 3'h5);
        bus(1'b1, REG_UART, 32'he3);
        bus(1'b1, REG_MODE, 32'h0205);
        bus(1'b1, REG_PIN, 32'h1234);
        bus(1'b1, REG_PEER_LO, 32'h11223344);
        bus(1'b1, REG_PEER_HI, 32'h5566);
        bus(1'b1, {REG_NAME_PAGE, 4'h0}, 32'h64636261);
        bus(1'b0, REG_PIN, 32'h0);
        check("pin readback", q[15:0], 16'h1234);
        check("pin before reboot", pin_code, PIN_DFLT);
        bus(1'b1, REG_CTRL, 32'h1);
        repeat (8) @(negedge core_clk);
        check("baud", uart_baud_sel, 4'h3);
        check("parity", uart_parity, PAR_EVEN);
        check("stop flow", {uart_stop2, uart_flow_en}, 2'b11);
        check("pin", pin_code, 16'h1234);
        check("peer", peer_addr, 48'h5566_1122_3344);
        check("name", device_name[31:0], 32'h64636261);
        check("master", {connect_req, advertise}, 2'b10);
        half(n);
        check("scan half period", n, FAST);
        $display("test config done");
    endtask
    task automatic t_link();
        int k;
        int j;
        int n;
        int st[3] = '{1, 1, 4};
        for (k = 0; k < 3; k++)
        begin
            @(posedge core_clk);
            peer_on <= 1'b1;
            for (j = 0; j < 60 && link_up !== 1'b1; j++)
                @(negedge core_clk);
            repeat (4) @(negedge core_clk);
            n = 0;
            repeat (12) @(negedge core_clk) n += int'(led_blue === 1'b1);
            check("linked blue", n, 12);
            @(posedge core_clk);
            peer_on <= 1'b0;
            repeat (6) @(negedge core_clk);
            bus(1'b0, REG_STATUS, 32'h0);
            check("state after drop", q[2:0], st[k]);
        end
        $display("test link done");
    endtask
    task automatic t_restore();
        int k;
        int n;
        int busy = 0;
        int rises = 0;
        logic prev;
        bus(1'b1, REG_PIN, 32'h9999);
        bus(1'b0, REG_PIN, 32'h0);
        check("refused write", q[15:0], 16'h1234);
        @(posedge core_clk);
        hold_restore <= 1'b1;
        repeat (HOLD - 6) @(negedge core_clk) busy += int'(restore_busy);
        @(posedge core_clk);
        hold_restore <= 1'b0;
        repeat (20) @(negedge core_clk) busy += int'(restore_busy);
        check("short press", busy, 0);
        @(posedge core_clk);
        hold_restore <= 1'b1;
        for (k = 0; k < HOLD + 10 && restore_busy !== 1'b1; k++)
            @(negedge core_clk);
        check("restore start", {restore_busy, k >= HOLD}, 2'b11);
        @(posedge core_clk);
        hold_restore <= 1'b0;
        prev = 1'b0;
        for (k = 0; k < 8 * FAST && restore_busy === 1'b1; k++)
        begin
            if (led_red === 1'b1 && prev === 1'b0)
                rises++;
            prev = led_red;
            @(negedge core_clk);
        end
        check("flash count", rises, 3);
        check("pin kept", pin_code, 16'h1234);
        bus(1'b1, REG_CTRL, 32'h1);
        repeat (8) @(negedge core_clk);
        check("pin default", pin_code, 16'h0000);
        check("uart default", {uart_baud_sel, uart_parity, uart_stop2,
            uart_flow_en}, {BAUD_115200, PAR_NONE, 2'b00});
        check("name default", device_name, NAME_DFLT);
        check("slave", {connect_req, advertise, reconnect_last},
            3'b011);
        half(n);
        check("wait half period", n, SLOW);
        bus(1'b0, 8'h40, 32'h0);
        check("unmapped read", q, 32'h0);
        $display("test restore done");
    endtask
    initial
    begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (20) @(negedge core_clk);
        t_config();
        t_link();
        t_restore();
        summarize();
    end
endmodule
